// *** rtl/fwsr_pkg.sv ***
// Package of the flash status poller: pin bit positions, counts, outcome and mode types.
// Assumes one 200 MHz clock and an asynchronous parallel NOR flash.
package fwsr_pkg;
	// ==========================================================
	// Status bit positions on the data bus
	localparam int POLL_BIT = 7; // Data polling bit
	localparam int TGL1_BIT = 6; // Toggle bit one
	localparam int TOUT_BIT = 5; // Timeout flag
	localparam int EWIN_BIT = 3; // Erase window flag
	localparam int TGL2_BIT = 2; // Toggle bit two
	localparam int ABRT_BIT = 1; // Buffer abort flag
	// ==========================================================
	// Bus timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int ACCESS_NS = 90; // Least read access time
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam logic [7:0] ACCESS_CNT = 8'(ACCESS_CYC);
	localparam logic [7:0] RECOVER_CNT = 8'h04; // High time between reads
	// ==========================================================
	// Widths and reset values
	localparam int ADDR_W = 22;
	localparam int DATA_W = 8;
	localparam logic [7:0] CNT_RST = 8'h00;
	// ==========================================================
	// Completion outcomes
	typedef enum logic [1:0] {
		FWSR_RES_OK = 2'b00,
		FWSR_RES_FAIL = 2'b01,
		FWSR_RES_ABORT = 2'b10
	} fwsr_res_t;
	// Poll method
	typedef enum logic {
		FWSR_M_TOGGLE = 1'b0,
		FWSR_M_POLL = 1'b1
	} fwsr_mode_t;
endpackage : fwsr_pkg

// *** rtl/fwsr_poller.sv ***
// Host-side completion detector for a NOR flash program or erase.
// Assumes the command sequence was written elsewhere; this block only reads
// status, watches the busy pin, and reports the outcome.
module fwsr_poller
	import fwsr_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic START,
	input wire fwsr_pkg::fwsr_mode_t MODE,
	input wire logic [fwsr_pkg::ADDR_W-1:0] ADDR,
	input wire logic [fwsr_pkg::DATA_W-1:0] EXP_DATA,
	input wire logic ABANDON,
	output logic BUSY,
	output logic DONE,
	output fwsr_pkg::fwsr_res_t RESULT,
	output logic [fwsr_pkg::DATA_W-1:0] FINAL_DATA,
	output logic ERASE_STARTED,
	output logic FLASH_CE_N,
	output logic FLASH_OE_N,
	output logic [fwsr_pkg::ADDR_W-1:0] FLASH_ADDR,
	input wire logic [fwsr_pkg::DATA_W-1:0] FLASH_DQ,
	input wire logic FLASH_READY_BUSY_N
);
	import fwsr_pkg::*;
	// ==========================================================
	// Sequencer state
	typedef enum logic [2:0] {
		FWSR_S_IDLE = 3'b000,
		FWSR_S_RD1 = 3'b001,
		FWSR_S_RD2 = 3'b010,
		FWSR_S_RD3 = 3'b011,
		FWSR_S_FIN = 3'b100,
		FWSR_S_DONE = 3'b101
	} fwsr_st_t;
	typedef struct packed {
		fwsr_st_t st;
		fwsr_mode_t mode;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] exp;
		logic [DATA_W-1:0] first; // Earlier read for compare
		logic tout_seen; // Timeout seen, recheck pending
		logic req;
		logic done;
		fwsr_res_t res;
		logic [DATA_W-1:0] fin;
		logic ewin;
		logic pend; // A read is still in flight in the engine
	} fwsr_state_t;
	fwsr_state_t s_r, s_nxt;
	fwsr_rd_if rd ();
	// ==========================================================
	// Read engine; one completed access per request
	fwsr_rd_engine u_eng (
		.clk(CLK),
		.rst_n(RST_N),
		.rd(rd),
		.ce_n(FLASH_CE_N),
		.oe_n(FLASH_OE_N),
		.addr_out(FLASH_ADDR),
		.data_in(FLASH_DQ)
	);
	// Polling bit reached its final value
	function automatic logic poll_done(input logic [DATA_W-1:0] d,
		input logic [DATA_W-1:0] e);
		poll_done = (d[POLL_BIT] == e[POLL_BIT]);
	endfunction : poll_done
	// ==========================================================
	// Sequencer: toggle method reads twice and compares, polling
	// method waits for the true bit and rereads
	always_comb begin
		s_nxt = s_r;
		s_nxt.req = 1'b0;
		s_nxt.done = 1'b0;
		// Track the engine so an abandoned read drains first
		if (rd.done) begin
			s_nxt.pend = 1'b0;
		end
		case (s_r.st)
			FWSR_S_IDLE: begin
				// A request during a draining read would be lost
				if (START && !s_r.pend) begin
					// Address is the programmed, last-buffer or erase-sector one
					s_nxt.addr = ADDR;
					s_nxt.exp = EXP_DATA;
					s_nxt.mode = MODE;
					s_nxt.tout_seen = 1'b0;
					s_nxt.ewin = 1'b0;
					s_nxt.st = FWSR_S_RD1;
					s_nxt.req = 1'b1;
				end
			end
			FWSR_S_RD1: begin
				if (ABANDON) begin
					s_nxt.st = FWSR_S_IDLE;
				end else if (rd.done) begin
					s_nxt.first = rd.data;
					s_nxt.st = FWSR_S_RD2;
					s_nxt.req = 1'b1;
				end
			end
			FWSR_S_RD2: begin
				if (ABANDON) begin
					s_nxt.st = FWSR_S_IDLE;
				end else if (rd.done) begin
					s_nxt.ewin = rd.data[EWIN_BIT];
					s_nxt.first = rd.data;
					s_nxt.req = 1'b1;
					if (s_r.mode == FWSR_M_TOGGLE) begin
						if (rd.data[TGL1_BIT] == s_r.first[TGL1_BIT]) begin
							s_nxt.st = FWSR_S_FIN;
							s_nxt.res = FWSR_RES_OK;
						end else if (s_r.tout_seen) begin
							s_nxt.st = FWSR_S_FIN;
							s_nxt.res = FWSR_RES_FAIL;
						end else if (rd.data[TOUT_BIT]) begin
							s_nxt.tout_seen = 1'b1;
							s_nxt.st = FWSR_S_RD2;
						end else begin
							s_nxt.st = FWSR_S_RD2;
						end
					end else begin
						if (poll_done(rd.data, s_r.exp)) begin
							s_nxt.st = FWSR_S_FIN;
							s_nxt.res = FWSR_RES_OK;
						end else if (rd.data[ABRT_BIT]) begin
							s_nxt.st = FWSR_S_FIN;
							s_nxt.res = FWSR_RES_ABORT;
						end else if (rd.data[TOUT_BIT]) begin
							s_nxt.st = FWSR_S_RD3;
						end else begin
							s_nxt.st = FWSR_S_RD2;
						end
					end
				end
			end
			FWSR_S_RD3: begin
				// Timeout seen: one more poll decides
				if (rd.done) begin
					s_nxt.st = FWSR_S_FIN;
					s_nxt.req = 1'b1;
					s_nxt.res = poll_done(rd.data, s_r.exp) ?
						FWSR_RES_OK : FWSR_RES_FAIL;
				end
			end
			FWSR_S_FIN: begin
				// Extra read gives valid data on all bits
				if (rd.done) begin
					s_nxt.fin = rd.data;
					s_nxt.done = 1'b1;
					s_nxt.st = FWSR_S_DONE;
				end
			end
			FWSR_S_DONE: begin
				s_nxt.st = FWSR_S_IDLE;
			end
			default: s_nxt.st = FWSR_S_IDLE;
		endcase
		// Every request leaves a read outstanding
		if (s_nxt.req) begin
			s_nxt.pend = 1'b1;
		end
	end
	// Register
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	// Outputs; the busy pin is a hint only, reads decide
	assign rd.req = s_r.req;
	assign rd.addr = s_r.addr;
	assign BUSY = (s_r.st != FWSR_S_IDLE) || s_r.pend
		|| !FLASH_READY_BUSY_N;
	assign DONE = s_r.done;
	assign RESULT = s_r.res;
	assign FINAL_DATA = s_r.fin;
	assign ERASE_STARTED = s_r.ewin;
	// ==========================================================
	// Checks
	done_after_fin_a: assert property (@(posedge CLK)
		disable iff (!RST_N) DONE |-> $past(s_r.st) == FWSR_S_FIN)
		else $error("done without a final read");
	same_toggle_ok_a: assert property (@(posedge CLK)
		disable iff (!RST_N)
		(s_r.st == FWSR_S_RD2 && rd.done && s_r.mode == FWSR_M_TOGGLE
		&& rd.data[TGL1_BIT] == s_r.first[TGL1_BIT]) |=>
		s_r.st == FWSR_S_FIN && s_r.res == FWSR_RES_OK)
		else $error("steady toggle not taken as done");
	fail_after_tout_a: assert property (@(posedge CLK)
		disable iff (!RST_N)
		(s_r.st == FWSR_S_RD2 && rd.done && s_r.tout_seen
		&& rd.data[TGL1_BIT] != s_r.first[TGL1_BIT]) |=>
		s_r.res == FWSR_RES_FAIL)
		else $error("toggling after timeout not failed");
	abandon_idle_a: assert property (@(posedge CLK)
		disable iff (!RST_N)
		(ABANDON && (s_r.st == FWSR_S_RD1 || s_r.st == FWSR_S_RD2))
		|=> s_r.st == FWSR_S_IDLE)
		else $error("abandon did not restart");
	busy_pin_a: assert property (@(posedge CLK)
		disable iff (!RST_N) !FLASH_READY_BUSY_N |-> BUSY)
		else $error("busy pin ignored");
	// Engine latches the address on the edge after the request
	read_addr_a: assert property (@(posedge CLK)
		disable iff (!RST_N)
		(s_r.st == FWSR_S_IDLE && START && !s_r.pend) |->
		##2 FLASH_ADDR == $past(ADDR, 2))
		else $error("poll address not the requested one");
	poll_ok_a: assert property (@(posedge CLK)
		disable iff (!RST_N)
		(s_r.st == FWSR_S_RD2 && rd.done && s_r.mode == FWSR_M_POLL
		&& rd.data[POLL_BIT] == s_r.exp[POLL_BIT]) |=>
		s_r.st == FWSR_S_FIN)
		else $error("true polling bit not taken");
	abort_res_a: assert property (@(posedge CLK)
		disable iff (!RST_N)
		(s_r.st == FWSR_S_RD2 && rd.done && s_r.mode == FWSR_M_POLL
		&& rd.data[POLL_BIT] != s_r.exp[POLL_BIT] && rd.data[ABRT_BIT])
		|=> s_r.res == FWSR_RES_ABORT)
		else $error("buffer abort not reported");
endmodule : fwsr_poller

// *** rtl/fwsr_rd_engine.sv ***
// Single read cycle engine: drives chip and output enable, samples data.
// Assumes a flash whose data settle within the access time after enables.
module fwsr_rd_engine
	import fwsr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	fwsr_rd_if.eng rd,
	output logic ce_n,
	output logic oe_n,
	output logic [ADDR_W-1:0] addr_out,
	input wire logic [DATA_W-1:0] data_in
);
	import fwsr_pkg::*;
	// ==========================================================
	// State
	typedef enum logic [1:0] {
		FWSR_E_IDLE = 2'b00,
		FWSR_E_ACC = 2'b01,
		FWSR_E_REC = 2'b10
	} fwsr_est_t;
	typedef struct packed {
		fwsr_est_t st;
		logic [7:0] cnt;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic done;
	} fwsr_eng_t;
	fwsr_eng_t s_r, s_nxt;
	// ==========================================================
	// Next state; each read ends by raising both enables, so the
	// device sees one completed access per request
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		case (s_r.st)
			FWSR_E_IDLE: begin
				if (rd.req) begin
					s_nxt.st = FWSR_E_ACC;
					s_nxt.addr = rd.addr;
					s_nxt.cnt = ACCESS_CNT;
				end
			end
			FWSR_E_ACC: begin
				// Sample at end of access time
				if (s_r.cnt == 8'h01) begin
					s_nxt.data = data_in;
					s_nxt.st = FWSR_E_REC;
					s_nxt.cnt = RECOVER_CNT;
				end else begin
					s_nxt.cnt = s_r.cnt - 8'h01;
				end
			end
			FWSR_E_REC: begin
				// Enables high: the read is closed
				if (s_r.cnt == 8'h01) begin
					s_nxt.st = FWSR_E_IDLE;
					s_nxt.done = 1'b1;
				end else begin
					s_nxt.cnt = s_r.cnt - 8'h01;
				end
			end
			default: s_nxt.st = FWSR_E_IDLE;
		endcase
	end
	// Register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign ce_n = (s_r.st != FWSR_E_ACC);
	assign oe_n = (s_r.st != FWSR_E_ACC);
	assign addr_out = s_r.addr;
	assign rd.done = s_r.done;
	assign rd.data = s_r.data;
	// Each read keeps the enables low for the full access time:
	// 18 cycles, 90 ns at 5 ns, then the enables rise again
	access_len_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		$fell(oe_n) |-> !oe_n [*8] ##1 !oe_n [*8] ##1 !oe_n [*2]
		##1 oe_n)
		else $error("read strobe not the full access time");
endmodule : fwsr_rd_engine

// *** rtl/fwsr_rd_if.sv ***
// Carrier between the poller sequencer and its bus read engine.
// Assumes both ends share CLK.
interface fwsr_rd_if;
	import fwsr_pkg::*;
	logic req; // Start one read
	logic [ADDR_W-1:0] addr; // Read address
	logic done; // One-cycle pulse, data valid
	logic [DATA_W-1:0] data; // Captured byte
	modport seq (output req, output addr, input done, input data);
	modport eng (input req, input addr, output done, output data);
endinterface : fwsr_rd_if

// *** testbench/fwsr_flash_model.sv ***
// Behavioural flash status responder facing the poller.
// Assumes the bench arms each operation and sets its outcome flags.
module fwsr_flash_model
	import fwsr_pkg::*;
(
	input wire logic ce_n, // Chip enable, low active
	input wire logic oe_n, // Output enable, low active
	input wire logic [fwsr_pkg::ADDR_W-1:0] addr, // Read address
	output logic [fwsr_pkg::DATA_W-1:0] dq, // Data pins
	output logic rdy_oe_n, // Low while pulling the busy pin
	input wire logic arm, // Starts an operation
	input wire logic [7:0] busy_reads, // Reads until completion
	input wire logic is_erase, // Erase rather than program
	input wire logic [fwsr_pkg::DATA_W-1:0] arr_data, // Byte when done
	input wire logic tout, // Timing limit overrun
	input wire logic abrt, // Buffer write aborted
	input wire logic susp, // Erase suspended
	input wire logic [fwsr_pkg::ADDR_W-1:0] tgt // Target or sector address
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Operation state
	logic [7:0] left = 8'h00; // Reads still busy
	logic tgl = 1'b0; // Toggle bit one state
	logic tgl2 = 1'b0; // Toggle bit two state
	logic [7:0] last = 8'h00; // Last byte driven
	logic busy; // Algorithm running
	logic [7:0] stat; // Status byte
	logic [7:0] seen; // Byte a read returns
	assign busy = (left != 8'h00);
	// Suspend releases the pin though status stays readable
	assign rdy_oe_n = !busy || susp;
	// Status byte; program never moves bit two
	assign stat = {is_erase ? susp : ~arr_data[7],
		tgl, tout, 1'b0, is_erase,
		is_erase & tgl2, abrt, 1'b0};
	// Polling bit is only valid at the target; elsewhere it lies
	assign seen = !busy ? arr_data
		: (addr == tgt) ? stat : stat ^ 8'h80;
	// Released bus shows the inverse, so a stale sample cannot match
	assign dq = (!ce_n && !oe_n) ? seen : ~last;
	// ==========================================================
	// One step per completed read, whichever enable ends it
	always @(posedge (ce_n | oe_n) or posedge arm) begin
		if (arm) begin
			left <= busy_reads;
		end else begin
			last <= seen;
			// Busy window counted in reads, then array data again
			if (busy) begin
				left <= left - 8'h01;
				tgl2 <= ~tgl2;
			end
			// Suspend freezes toggle bit one
			if (busy && !susp) begin
				tgl <= ~tgl;
			end
		end
	end
endmodule : fwsr_flash_model

// *** testbench/fwsr_poller_test.sv ***
// Self-checking bench of the flash status poller.
// Assumes the flash model above; the busy pin has a pull-up.
module fwsr_poller_test;
	timeunit 1ns;
	timeprecision 100ps;
	import fwsr_pkg::*;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
	// ==========================================================
	// Signals
	logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, abandon = 1'b0;
	fwsr_mode_t mode = FWSR_M_TOGGLE; // Check method
	logic [ADDR_W-1:0] addr = 22'h01a2b4, fl_addr; // Target address
	logic [7:0] exp_data = 8'h00, final_data, arr_data = 8'h00;
	logic busy, done, erase_started, ce_n, oe_n, rdy_oe_n;
	fwsr_res_t result; // Outcome
	wire [7:0] dq; // Flash data
	wire rdy_n = rdy_oe_n ? 1'b1 : 1'b0; // Pull-up resolution
	logic arm = 1'b0, is_erase = 1'b0, tout = 1'b0, abrt = 1'b0;
	logic susp = 1'b0; // Model in erase suspend
	logic [7:0] busy_reads = 8'h00; // Model busy length
	int n_errors = 0, n_tests = 0;
	fwsr_poller i_dut (.CLK(clk), .RST_N(rst_n), .START(start),
		.MODE(mode), .ADDR(addr), .EXP_DATA(exp_data),
		.ABANDON(abandon), .BUSY(busy), .DONE(done), .RESULT(result),
		.FINAL_DATA(final_data), .ERASE_STARTED(erase_started),
		.FLASH_CE_N(ce_n), .FLASH_OE_N(oe_n), .FLASH_ADDR(fl_addr),
		.FLASH_DQ(dq), .FLASH_READY_BUSY_N(rdy_n));
	fwsr_flash_model i_flash (.ce_n(ce_n), .oe_n(oe_n), .addr(fl_addr),
		.dq(dq), .rdy_oe_n(rdy_oe_n), .arm(arm),
		.busy_reads(busy_reads), .is_erase(is_erase),
		.arr_data(arr_data), .tout(tout), .abrt(abrt), .susp(susp),
		.tgt(addr));
	initial begin
		forever #2.5 clk = ~clk;
	end
	// ==========================================================
	// Tasks
	task automatic report_and_stop;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	// Arms the model with how the operation will end
	task automatic arm_op(input logic [7:0] n, input logic er,
		input logic [7:0] d, input logic to, input logic ab);
		busy_reads = n;
		is_erase = er;
		arr_data = d;
		tout = to;
		abrt = ab;
		arm = 1'b1;
		@(posedge clk) #1;
		arm = 1'b0;
	endtask : arm_op
	// One check from START to DONE, bounded wait
	task automatic run(input fwsr_mode_t m, input fwsr_res_t want);
		int i;
		mode = m;
		exp_data = arr_data;
		start = 1'b1;
		@(posedge clk) #1;
		start = 1'b0;
		repeat (2) @(posedge clk) #1;
		`CHK(fl_addr, addr)
		for (i = 0; i < 5000 && done !== 1'b1; i++) @(posedge clk) #1;
		if (done !== 1'b1) begin
			n_errors++;
			$display("[ERR] %0t no completion", $time);
			report_and_stop();
		end
		`CHK(result, want)
		if (want == FWSR_RES_OK && !susp) `CHK(final_data, arr_data)
		@(posedge clk) #1;
	endtask : run
	// ==========================================================
	// Scenarios
	initial begin
		repeat (10) @(posedge clk);
		#1 rst_n = 1'b1;
		arm_op(8'h05, 1'b0, 8'h5a, 1'b0, 1'b0);
		`CHK(busy, 1'b1)
		run(FWSR_M_TOGGLE, FWSR_RES_OK);
		`CHK(busy, 1'b0)
		arm_op(8'h04, 1'b0, 8'ha5, 1'b0, 1'b0);
		run(FWSR_M_POLL, FWSR_RES_OK);
		arm_op(8'h06, 1'b1, 8'hff, 1'b0, 1'b0);
		run(FWSR_M_POLL, FWSR_RES_OK);
		`CHK(erase_started, 1'b1)
		arm_op(8'h06, 1'b1, 8'hff, 1'b0, 1'b0);
		run(FWSR_M_TOGGLE, FWSR_RES_OK);
		// Still toggling with the overrun flag up
		arm_op(8'hff, 1'b0, 8'h00, 1'b1, 1'b0);
		run(FWSR_M_TOGGLE, FWSR_RES_FAIL);
		arm_op(8'hff, 1'b0, 8'h3c, 1'b0, 1'b1);
		run(FWSR_M_POLL, FWSR_RES_ABORT);
		// Erase suspended: toggle stops, polling bit true, pin released
		susp = 1'b1;
		arm_op(8'hff, 1'b1, 8'hff, 1'b0, 1'b0);
		run(FWSR_M_TOGGLE, FWSR_RES_OK);
		`CHK(final_data[POLL_BIT], 1'b1)
		`CHK(busy, 1'b0)
		susp = 1'b0;
		// Abandon mid-check, then a fresh check from the start
		arm_op(8'hff, 1'b0, 8'h66, 1'b0, 1'b0);
		start = 1'b1;
		@(posedge clk) #1;
		start = 1'b0;
		repeat (30) @(posedge clk) #1;
		abandon = 1'b1;
		repeat (30) @(posedge clk) #1;
		`CHK(ce_n, 1'b1)
		arm_op(8'h00, 1'b0, 8'h66, 1'b0, 1'b0);
		`CHK(busy, 1'b0)
		abandon = 1'b0;
		arm_op(8'h03, 1'b0, 8'h66, 1'b0, 1'b0);
		run(FWSR_M_TOGGLE, FWSR_RES_OK);
		report_and_stop();
	end
endmodule : fwsr_poller_test
